// File: hw/tmrsa_regs.sv
// tmrsa_regs: register bank, offset correction, limit compare, status
// flags and alert latch of the two-channel temperature monitor.
// assumes: a bus engine decodes frames into byte strobes on clk; an
// analog front end hands raw results with a one-cycle valid strobe.
`timescale 1ns/100ps

module tmrsa_regs #(
  parameter int          BASE_CYC    = tmrsa_pkg::BASE_PERIOD_CYC,
  parameter int          BUSY_LEN    = tmrsa_pkg::BUSY_CYC,
  parameter logic [7:0]  MAKER_CODE  = 8'h5a, // arbitrary value
  parameter logic [7:0]  REV_CODE    = 8'h01  // arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        wr_first,
  input  wire logic        wr_data,
  input  wire logic [7:0]  wr_byte,
  input  wire logic        rd_req,
  input  wire logic        ara_read,
  input  wire logic        standby_pin_n,
  input  wire logic        conv_valid,
  input  wire logic [10:0] local_raw,
  input  wire logic [10:0] remote_raw,
  input  wire logic        sensor_open,
  output logic [7:0]       rd_byte,
  output logic             conv_start,
  output logic             alert_n
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef enum {TMRSA_IDLE, TMRSA_BUSY} tmrsa_conv_t;
  tmrsa_conv_t conv_state;

  logic [7:0]  addr_ptr;
  logic [7:0]  local_temp_value;
  logic [7:0]  remote_temp_value_hi;
  logic [7:0]  remote_temp_value_lo;
  logic [7:0]  device_config;
  logic [7:0]  conv_rate_select;
  logic [7:0]  local_high_limit;
  logic [7:0]  local_low_limit;
  logic [7:0]  remote_high_limit_hi;
  logic [7:0]  remote_low_limit_hi;
  logic [7:0]  remote_high_limit_lo;
  logic [7:0]  remote_low_limit_lo;
  logic [7:0]  remote_offset_hi;
  logic [7:0]  remote_offset_lo;
  logic        local_over_flag;
  logic        local_under_flag;
  logic        remote_over_flag;
  logic        remote_under_flag;
  logic        open_flag;
  logic        alert_latch;
  logic        one_shot_req;
  logic [31:0] rate_cnt;
  logic [31:0] busy_cnt;
  logic [2:0]  standby_pin_sync;

  // ****************************************************************
  // standby pin synchroniser, three stages
  // ****************************************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      standby_pin_sync <= 3'h7; // idle pin level, no false standby after reset
    end else begin
      standby_pin_sync <= {standby_pin_sync[1:0], standby_pin_n};
    end
  end

  logic standby_pin_level;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      standby_pin_level <= 1'b1;
    end else if (standby_pin_sync[2] == standby_pin_sync[1]) begin
      standby_pin_level <= standby_pin_sync[2];
    end
  end

  logic standby;
  assign standby = device_config[tmrsa_pkg::CFG_STOP_BIT] | ~standby_pin_level;

  // ****************************************************************
  // address pointer and writable registers
  // ****************************************************************
  // first byte of every write is the pointer
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      addr_ptr <= 8'h00;
    end else if (wr_first) begin
      addr_ptr <= wr_byte;
    end
  end

  logic wr_ok;
  assign wr_ok = wr_data & (addr_ptr <= tmrsa_pkg::WR_LAST_LEGAL);

  // write-address decode; read-only addresses take no write
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      device_config        <= tmrsa_pkg::RST_CONFIG;
      conv_rate_select     <= tmrsa_pkg::RST_RATE;
      local_high_limit     <= tmrsa_pkg::RST_HIGH_LIM;
      local_low_limit      <= tmrsa_pkg::RST_LOW_LIM;
      remote_high_limit_hi <= tmrsa_pkg::RST_HIGH_LIM;
      remote_low_limit_hi  <= tmrsa_pkg::RST_LOW_LIM;
      remote_high_limit_lo <= tmrsa_pkg::RST_ZERO;
      remote_low_limit_lo  <= tmrsa_pkg::RST_ZERO;
      remote_offset_hi     <= tmrsa_pkg::RST_ZERO;
      remote_offset_lo     <= tmrsa_pkg::RST_ZERO;
    end else if (wr_ok) begin
      if (addr_ptr == tmrsa_pkg::WR_CONFIG) begin
        device_config <= {wr_byte[7:6], 6'h00};
      end else if (addr_ptr == tmrsa_pkg::WR_RATE) begin
        conv_rate_select <= {5'h00, wr_byte[2:0]};
      end else if (addr_ptr == tmrsa_pkg::WR_LOCAL_HIGH_LIM) begin
        local_high_limit <= wr_byte;
      end else if (addr_ptr == tmrsa_pkg::WR_LOCAL_LOW_LIM) begin
        local_low_limit <= wr_byte;
      end else if (addr_ptr == tmrsa_pkg::WR_REMOTE_HIGH_HI) begin
        remote_high_limit_hi <= wr_byte;
      end else if (addr_ptr == tmrsa_pkg::WR_REMOTE_LOW_HI) begin
        remote_low_limit_hi <= wr_byte;
      end else if (addr_ptr == tmrsa_pkg::ADDR_OFFSET_HI) begin
        remote_offset_hi <= wr_byte;
      end else if (addr_ptr == tmrsa_pkg::ADDR_OFFSET_LO) begin
        remote_offset_lo <= {wr_byte[7:5], 5'h00};
      end else if (addr_ptr == tmrsa_pkg::ADDR_REMOTE_HIGH_LO) begin
        remote_high_limit_lo <= {wr_byte[7:5], 5'h00};
      end else if (addr_ptr == tmrsa_pkg::ADDR_REMOTE_LOW_LO) begin
        remote_low_limit_lo <= {wr_byte[7:5], 5'h00};
      end
    end
  end

  // ****************************************************************
  // conversion scheduling
  // ****************************************************************
  // divided period: base times 2^(7-code)
  logic [31:0] period_cyc;
  assign period_cyc = 32'(BASE_CYC) << (3'h7 - conv_rate_select[2:0]);

  // one-shot write request, held until a conversion starts
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      one_shot_req <= 1'b0;
    end else if (wr_ok && addr_ptr == tmrsa_pkg::WR_ONE_SHOT) begin
      one_shot_req <= 1'b1;
    end else if (conv_state == TMRSA_IDLE) begin
      one_shot_req <= 1'b0;
    end
  end

  // free-running rate timer while not in standby
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rate_cnt <= 32'h0;
    end else if (standby || rate_cnt >= period_cyc - 32'h1) begin
      rate_cnt <= 32'h0;
    end else begin
      rate_cnt <= rate_cnt + 32'h1;
    end
  end

  logic rate_tick;
  assign rate_tick = ~standby & (rate_cnt >= period_cyc - 32'h1);

  // busy window from start to result
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      conv_state <= TMRSA_IDLE;
      conv_start <= 1'b0;
      busy_cnt   <= 32'h0;
    end else begin
      conv_start <= 1'b0;
      case (conv_state)
        TMRSA_IDLE: begin
          if (rate_tick || one_shot_req) begin
            conv_state <= TMRSA_BUSY;
            conv_start <= 1'b1;
            busy_cnt   <= 32'h0;
          end
        end
        TMRSA_BUSY: begin
          busy_cnt <= busy_cnt + 32'h1;
          if (conv_valid || busy_cnt >= 32'(BUSY_LEN) - 32'h1) begin
            conv_state <= TMRSA_IDLE;
          end
        end
        default: conv_state <= TMRSA_IDLE;
      endcase
    end
  end

  logic take_result;
  assign take_result = conv_valid & (conv_state == TMRSA_BUSY);

  // ****************************************************************
  // offset correction with saturation, 11-bit eighth-degree units
  // ****************************************************************
  logic signed [12:0] offset_sum;
  logic [10:0]        remote_corr;
  assign offset_sum = $signed({2'b00, remote_raw})
                    + $signed({{2{remote_offset_hi[7]}}, remote_offset_hi,
                               remote_offset_lo[7:5]});
  always_comb begin
    if (offset_sum > 13'sd1023) begin
      remote_corr = 11'h3ff;
    end else if (offset_sum < -13'sd1024) begin
      remote_corr = 11'h400;
    end else begin
      remote_corr = offset_sum[10:0];
    end
  end

  // value registers load only from the converter
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      local_temp_value     <= tmrsa_pkg::RST_VALUE;
      remote_temp_value_hi <= tmrsa_pkg::RST_VALUE;
      remote_temp_value_lo <= tmrsa_pkg::RST_ZERO;
    end else if (take_result) begin
      local_temp_value     <= local_raw[10:3];
      remote_temp_value_hi <= remote_corr[10:3];
      remote_temp_value_lo <= {remote_corr[2:0], 5'h00};
    end
  end

  // ****************************************************************
  // limit comparison on stored values
  // ****************************************************************
  logic signed [10:0] remote_val;
  logic signed [10:0] remote_hi_lim;
  logic signed [10:0] remote_lo_lim;
  logic               local_over;
  logic               local_under;
  logic               remote_over;
  logic               remote_under;
  assign remote_val    = {remote_temp_value_hi, remote_temp_value_lo[7:5]};
  assign remote_hi_lim = {remote_high_limit_hi, remote_high_limit_lo[7:5]};
  assign remote_lo_lim = {remote_low_limit_hi, remote_low_limit_lo[7:5]};
  assign local_over    = $signed(local_temp_value) > $signed(local_high_limit);
  assign local_under   = $signed(local_temp_value) < $signed(local_low_limit);
  assign remote_over   = remote_val > remote_hi_lim;
  assign remote_under  = remote_val < remote_lo_lim;

  // ****************************************************************
  // sticky flags; set wins, read clears only ended causes
  // ****************************************************************
  logic status_rd;
  assign status_rd = rd_req & (addr_ptr == tmrsa_pkg::RD_STATUS);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      local_over_flag   <= 1'b0;
      local_under_flag  <= 1'b0;
      remote_over_flag  <= 1'b0;
      remote_under_flag <= 1'b0;
      open_flag         <= 1'b0;
    end else begin
      local_over_flag   <= local_over | (local_over_flag & ~status_rd);
      local_under_flag  <= local_under | (local_under_flag & ~status_rd);
      remote_over_flag  <= remote_over | (remote_over_flag & ~status_rd);
      remote_under_flag <= remote_under | (remote_under_flag & ~status_rd);
      open_flag         <= sensor_open | (open_flag & ~status_rd);
    end
  end

  logic any_flag;
  assign any_flag = local_over_flag | local_under_flag | remote_over_flag
                  | remote_under_flag | open_flag;

  // alert latch: set by flags, cleared by alert-address read when clean
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      alert_latch <= 1'b0;
    end else if (any_flag) begin
      alert_latch <= 1'b1;
    end else if (ara_read) begin
      alert_latch <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      alert_n <= 1'b1;
    end else begin
      alert_n <= ~((alert_latch | any_flag) & ~device_config[tmrsa_pkg::CFG_MASK_BIT]);
    end
  end

  // ****************************************************************
  // read mux, registered at the read strobe
  // ****************************************************************
  logic [7:0] status_byte;
  assign status_byte = {conv_state == TMRSA_BUSY, local_over_flag, local_under_flag,
                        remote_over_flag, remote_under_flag, open_flag, 2'b00};

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_byte <= 8'h00;
    end else if (rd_req) begin
      if (addr_ptr == tmrsa_pkg::RD_LOCAL_VALUE) begin
        rd_byte <= local_temp_value;
      end else if (addr_ptr == tmrsa_pkg::RD_REMOTE_HI) begin
        rd_byte <= remote_temp_value_hi;
      end else if (addr_ptr == tmrsa_pkg::RD_STATUS) begin
        rd_byte <= status_byte;
      end else if (addr_ptr == tmrsa_pkg::RD_CONFIG) begin
        rd_byte <= device_config;
      end else if (addr_ptr == tmrsa_pkg::RD_RATE) begin
        rd_byte <= conv_rate_select;
      end else if (addr_ptr == tmrsa_pkg::RD_LOCAL_HIGH_LIM) begin
        rd_byte <= local_high_limit;
      end else if (addr_ptr == tmrsa_pkg::RD_LOCAL_LOW_LIM) begin
        rd_byte <= local_low_limit;
      end else if (addr_ptr == tmrsa_pkg::RD_REMOTE_HIGH_HI) begin
        rd_byte <= remote_high_limit_hi;
      end else if (addr_ptr == tmrsa_pkg::RD_REMOTE_LOW_HI) begin
        rd_byte <= remote_low_limit_hi;
      end else if (addr_ptr == tmrsa_pkg::RD_REMOTE_LO) begin
        rd_byte <= remote_temp_value_lo;
      end else if (addr_ptr == tmrsa_pkg::ADDR_OFFSET_HI) begin
        rd_byte <= remote_offset_hi;
      end else if (addr_ptr == tmrsa_pkg::ADDR_OFFSET_LO) begin
        rd_byte <= remote_offset_lo;
      end else if (addr_ptr == tmrsa_pkg::ADDR_REMOTE_HIGH_LO) begin
        rd_byte <= remote_high_limit_lo;
      end else if (addr_ptr == tmrsa_pkg::ADDR_REMOTE_LOW_LO) begin
        rd_byte <= remote_low_limit_lo;
      end else if (addr_ptr == tmrsa_pkg::RD_MAKER_ID) begin
        rd_byte <= MAKER_CODE;
      end else if (addr_ptr == tmrsa_pkg::RD_REVISION) begin
        rd_byte <= REV_CODE;
      end else begin
        rd_byte <= 8'h00;
      end
    end
  end

endmodule

// File: pkg/tmrsa_pkg.sv
// tmrsa_pkg: register addresses, reset values, field positions and timing
// constants for the two-channel temperature monitor register bank.
// assumes: included in compile order before hw/tmrsa_regs.sv.
package tmrsa_pkg;

  // ****************************************************************
  // read addresses
  // ****************************************************************
  localparam logic [7:0] RD_LOCAL_VALUE     = 8'h00;
  localparam logic [7:0] RD_REMOTE_HI       = 8'h01;
  localparam logic [7:0] RD_STATUS          = 8'h02;
  localparam logic [7:0] RD_CONFIG          = 8'h03;
  localparam logic [7:0] RD_RATE            = 8'h04;
  localparam logic [7:0] RD_LOCAL_HIGH_LIM  = 8'h05;
  localparam logic [7:0] RD_LOCAL_LOW_LIM   = 8'h06;
  localparam logic [7:0] RD_REMOTE_HIGH_HI  = 8'h07;
  localparam logic [7:0] RD_REMOTE_LOW_HI   = 8'h08;
  localparam logic [7:0] RD_REMOTE_LO       = 8'h10;
  localparam logic [7:0] ADDR_OFFSET_HI     = 8'h11;
  localparam logic [7:0] ADDR_OFFSET_LO     = 8'h12;
  localparam logic [7:0] ADDR_REMOTE_HIGH_LO = 8'h13;
  localparam logic [7:0] ADDR_REMOTE_LOW_LO = 8'h14;
  localparam logic [7:0] RD_RESERVED_A      = 8'h19;
  localparam logic [7:0] RD_RESERVED_B      = 8'h20;
  localparam logic [7:0] RD_MAKER_ID        = 8'hfe;
  localparam logic [7:0] RD_REVISION        = 8'hff;

  // ****************************************************************
  // write addresses
  // ****************************************************************
  localparam logic [7:0] WR_CONFIG          = 8'h09;
  localparam logic [7:0] WR_RATE            = 8'h0a;
  localparam logic [7:0] WR_LOCAL_HIGH_LIM  = 8'h0b;
  localparam logic [7:0] WR_LOCAL_LOW_LIM   = 8'h0c;
  localparam logic [7:0] WR_REMOTE_HIGH_HI  = 8'h0d;
  localparam logic [7:0] WR_REMOTE_LOW_HI   = 8'h0e;
  localparam logic [7:0] WR_ONE_SHOT        = 8'h0f;
  localparam logic [7:0] WR_LAST_LEGAL      = 8'h14;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] RST_VALUE          = 8'h80;
  localparam logic [7:0] RST_HIGH_LIM       = 8'h7f;
  localparam logic [7:0] RST_LOW_LIM        = 8'hc9;
  localparam logic [7:0] RST_CONFIG         = 8'h00;
  localparam logic [7:0] RST_RATE           = 8'h02;
  localparam logic [7:0] RST_ZERO           = 8'h00;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CFG_MASK_BIT   = 7;
  localparam int CFG_STOP_BIT   = 6;
  localparam int ST_BUSY_BIT    = 7;
  localparam int ST_LOCAL_OVER_FLAG_BIT   = 6;
  localparam int ST_LOCAL_UNDER_FLAG_BIT    = 5;
  localparam int ST_REMOTE_OVER_FLAG_BIT   = 4;
  localparam int ST_REMOTE_UNDER_FLAG_BIT    = 3;
  localparam int ST_OPEN_BIT    = 2;
  localparam int RATE_BITS      = 3;
  localparam int FRAC_BITS      = 3;

  // ****************************************************************
  // timing: slowest conversion period is 16 s at code 0
  // ****************************************************************
  localparam int CLK_MHZ        = 200;
  localparam int BASE_PERIOD_MS = 125;
  localparam int BASE_PERIOD_CYC = BASE_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int BUSY_TIME_US   = 10;
  localparam int BUSY_CYC       = BUSY_TIME_US * CLK_MHZ;

endpackage

// File: bench/tmrsa_regs_sva.sv
// tmrsa_regs_sva: port-level checks of the temperature monitor register bank.
// assumes: bound to tmrsa_regs; bus strobes last one cycle each.
`timescale 1ns/100ps
module tmrsa_regs_chk (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       wr_first,
  input wire logic       wr_data,
  input wire logic [7:0] wr_byte,
  input wire logic       rd_req,
  input wire logic       ara_read,
  input wire logic       conv_valid,
  input wire logic       sensor_open,
  input wire logic [7:0] rd_byte,
  input wire logic       conv_start,
  input wire logic       alert_n
);
  logic [7:0] ptr;
  logic [5:0] set_hist;
  logic [3:0] clr_hist;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // ****
  // helper logic
  // ****
  // mirror of the address pointer
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ptr <= 8'h00;
    end else if (wr_first) begin
      ptr <= wr_byte;
    end
  end
  // recent events that may pull or release the alert
  always_ff @(posedge clk) begin
    set_hist <= {set_hist[4:0], conv_valid | wr_data | sensor_open | reset};
    clr_hist <= {clr_hist[2:0], ara_read | wr_data};
  end
  a_start_single: assert property (conv_start |=> !conv_start)
    else $error("conversion start wider than one cycle");
  a_oneshot_start: assert property (wr_data && ptr == 8'h0f |-> ##[1:40] conv_start)
    else $error("one-shot write did not start a conversion");
  a_read_hold: assert property (!rd_req && !$past(rd_req) |=> $stable(rd_byte))
    else $error("read data changed without a read");
  a_wronly_zero: assert property (
    rd_req && (ptr == 8'h09 || ptr == 8'h0f || ptr == 8'h19) |-> ##2 rd_byte == 8'h00)
    else $error("write-only or reserved address read nonzero");
  a_config_bits: assert property (rd_req && ptr == 8'h03 |-> ##2 rd_byte[5:0] == 6'h00)
    else $error("config reserved bits nonzero");
  a_rate_bits: assert property (rd_req && ptr == 8'h04 |-> ##2 rd_byte[7:3] == 5'h00)
    else $error("rate unused bits nonzero");
  a_fraction_bits: assert property (
    rd_req && (ptr == 8'h10 || ptr == 8'h12) |-> ##2 rd_byte[4:0] == 5'h00)
    else $error("low byte bits 4..0 nonzero");
  a_status_rsvd: assert property (rd_req && ptr == 8'h02 |-> ##2 rd_byte[1:0] == 2'h0)
    else $error("status reserved bits nonzero");
  a_alert_cause: assert property ($fell(alert_n) |-> |set_hist)
    else $error("alert fell without a cause");
  a_alert_clear: assert property ($rose(alert_n) |-> |clr_hist)
    else $error("alert released without service or mask");
endmodule

bind tmrsa_regs tmrsa_regs_chk chk (
  .clk(clk), .reset(reset), .wr_first(wr_first), .wr_data(wr_data),
  .wr_byte(wr_byte), .rd_req(rd_req), .ara_read(ara_read), .conv_valid(conv_valid),
  .sensor_open(sensor_open), .rd_byte(rd_byte), .conv_start(conv_start),
  .alert_n(alert_n)
);

// File: bench/tmrsa_host.sv
// tmrsa_host: bus master model issuing byte strobes to the register bank.
// assumes: strobes launched at the falling edge, one cycle wide.
`timescale 1ns/100ps
module tmrsa_host (
  input  wire logic [7:0] rd_byte,
  input  wire logic       clk,
  output logic            wr_first,
  output logic            wr_data,
  output logic [7:0]      wr_byte,
  output logic            rd_req,
  output logic            ara_read
);
  // ****
  // bus cycles
  // ****
  // idle bus at time zero
  initial begin
    {wr_first, wr_data, rd_req, ara_read} = 4'h0;
    wr_byte = 8'h00;
  end
  // one strobe for one cycle; released byte shows the inverse
  task automatic pulse(input logic [3:0] s, input logic [7:0] b);
    @(negedge clk);
    {wr_first, wr_data, rd_req, ara_read} <= s;
    wr_byte <= b;
    @(negedge clk);
    {wr_first, wr_data, rd_req, ara_read} <= 4'h0;
    wr_byte <= ~b;
  endtask
  // pointer byte then data byte; callers keep addresses at or below 0x14
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    pulse(4'b1000, a);
    pulse(4'b0100, d);
  endtask
  // pointer byte then a read, answer taken once it has settled
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    pulse(4'b1000, a);
    pulse(4'b0010, 8'h00);
    @(negedge clk);
    d = rd_byte;
  endtask
endmodule

// File: bench/tmrsa_regs_tb.sv
// tmrsa_regs_tb: directed register, conversion and alert tests.
// assumes: tmrsa_host drives the bus; front end is modelled here.
`timescale 1ns/100ps
module tmrsa_regs_tb;
  localparam logic [7:0] MK = 8'h5c; // arbitrary value
  localparam logic [7:0] RV = 8'h07; // arbitrary value
  localparam logic [15:0] DFLT [19] = '{16'h0080, 16'h0180, 16'h0300, 16'h0402,
    16'h057f, 16'h06c9, 16'h077f, 16'h08c9, 16'h1000, 16'h1100, 16'h1200, 16'h1300,
    16'h1400, 16'h1900, 16'h2000, 16'h0900, 16'h0f00, {8'hfe, MK}, {8'hff, RV}};
  localparam logic [31:0] LIM [8] = '{32'h0b055a5a, 32'h0c060a0a, 32'h0d076464,
    32'h0e080505, 32'h1111fcfc, 32'h1212ffe0, 32'h1313ffe0, 32'h14143f20};
  logic        clk;
  logic        reset;
  logic        wr_first;
  logic        wr_data;
  logic [7:0]  wr_byte;
  logic        rd_req;
  logic        ara_read;
  logic        standby_pin_n;
  logic        conv_valid;
  logic [10:0] local_raw;
  logic [10:0] remote_raw;
  logic        sensor_open;
  logic [7:0]  rd_byte;
  logic        conv_start;
  logic        alert_n;
  logic [7:0]  d;
  int          failures;
  int          checks_done;
  int          n;

  tmrsa_regs #(.BASE_CYC(20), .BUSY_LEN(8), .MAKER_CODE(MK), .REV_CODE(RV)) uut (
    .clk(clk), .reset(reset), .wr_first(wr_first), .wr_data(wr_data),
    .wr_byte(wr_byte), .rd_req(rd_req), .ara_read(ara_read),
    .standby_pin_n(standby_pin_n), .conv_valid(conv_valid), .local_raw(local_raw),
    .remote_raw(remote_raw), .sensor_open(sensor_open), .rd_byte(rd_byte),
    .conv_start(conv_start), .alert_n(alert_n));
  tmrsa_host host (.rd_byte(rd_byte), .clk(clk), .wr_first(wr_first), .wr_data(wr_data),
    .wr_byte(wr_byte), .rd_req(rd_req), .ara_read(ara_read));

  // ****
  // clock, front end and helpers
  // ****
  always #2.5 clk = ~clk;
  // front end answers each start a few cycles later
  always @(negedge clk) begin
    if (conv_start === 1'b1) begin
      repeat (3) @(negedge clk);
      conv_valid <= 1'b1;
      @(negedge clk);
      conv_valid <= 1'b0;
    end
  end
  task automatic summarize();
    if (failures == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    host.read(a, d);
    check(d, exp);
  endtask
  task automatic alert(input logic exp);
    repeat (3) @(negedge clk);
    check({7'h00, alert_n}, {7'h00, exp});
  endtask
  // one-shot conversion with the given raw results
  task automatic convert(input logic [10:0] l, input logic [10:0] r);
    local_raw <= l;
    remote_raw <= r;
    host.write(8'h0f, 8'h00);
    n = 0;
    while (conv_valid !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    if (n >= 50) begin
      failures++;
      $display("unexpected at %0t: no conversion result", $time);
      summarize();
    end
    repeat (4) @(negedge clk);
  endtask
  // cycles between two consecutive conversion starts
  task automatic gap(output int c);
    for (int k = 0; k < 2; k++) begin
      c = 0;
      @(negedge clk);
      while (conv_start !== 1'b1 && c < 3000) begin
        @(negedge clk);
        c++;
      end
      if (c >= 3000) begin
        failures++;
        $display("unexpected at %0t: no conversion start", $time);
        summarize();
      end
    end
    c++;
  endtask

  // ****
  // main sequence
  // ****
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    standby_pin_n = 1'b0;
    conv_valid = 1'b0;
    local_raw = 11'h000;
    remote_raw = 11'h000;
    sensor_open = 1'b0;
    failures = 0;
    checks_done = 0;
    repeat (12) @(negedge clk);
    reset <= 1'b0;
    foreach (DFLT[i]) rd(DFLT[i][15:8], DFLT[i][7:0]);
    alert(1'b0);
    host.write(8'h00, 8'h55);
    rd(8'h00, 8'h80);
    host.write(8'h09, 8'hff);
    rd(8'h03, 8'hc0);
    alert(1'b1);
    host.write(8'h0a, 8'hff);
    rd(8'h04, 8'h07);
    foreach (LIM[i]) begin
      host.write(LIM[i][31:24], LIM[i][15:8]);
      rd(LIM[i][23:16], LIM[i][7:0]);
    end
    standby_pin_n <= 1'b1;
    host.write(8'h0f, 8'h00);
    rd(8'h02, 8'ha8);
    convert(11'd205, 11'd144);
    rd(8'h00, 8'h19);
    rd(8'h01, 8'h0e);
    rd(8'h10, 8'he0);
    rd(8'h02, 8'h28);
    rd(8'h02, 8'h00);
    host.write(8'h09, 8'h40);
    alert(1'b0);
    host.pulse(4'b0001, 8'h00);
    alert(1'b1);
    host.write(8'h0b, 8'h19);
    rd(8'h02, 8'h00);
    host.write(8'h0b, 8'h18);
    rd(8'h02, 8'h40);
    rd(8'h02, 8'h40);
    alert(1'b0);
    host.write(8'h11, 8'h7f);
    host.write(8'h12, 8'he0);
    convert(11'd205, 11'd1023);
    rd(8'h01, 8'h7f);
    rd(8'h10, 8'he0);
    sensor_open <= 1'b1;
    rd(8'h02, 8'h54);
    sensor_open <= 1'b0;
    host.write(8'h09, 8'h00);
    for (int c = 7; c >= 5; c -= 2) begin
      host.write(8'h0a, 8'(c));
      gap(n);
      check(8'(n), 8'(20 << (7 - c)));
    end
    // stop bit first, then the standby pin
    for (int s = 0; s < 2; s++) begin
      if (s == 0) begin
        host.write(8'h09, 8'h40);
      end else begin
        host.write(8'h09, 8'h00);
        standby_pin_n <= 1'b0;
      end
      repeat (10) @(negedge clk);
      n = 0;
      repeat (300) begin
        @(negedge clk);
        if (conv_start === 1'b1) n++;
      end
      check(8'(n), 8'h00);
    end
    summarize();
  end
endmodule
